/* File: src/sprre_pkg.sv */
// Package for the stack pop, rotate and return execution unit.
// Assumes one 250 MHz clock domain and an AXI4-Lite master with 32-bit data.
package sprre_pkg;

  // Register offsets on the AXI4-Lite bus.
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ACCS = 8'h08;
  localparam logic [7:0] OFF_PTRS = 8'h0C;

  // Field positions.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OPND_LSB = 8;
  localparam int CMD_PRE_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BAD_BIT = 1;
  localparam int STAT_STEP_LSB = 8;
  localparam int CC_V = 7;
  localparam int CC_H = 4;
  localparam int CC_I = 3;
  localparam int CC_N = 2;
  localparam int CC_Z = 1;
  localparam int CC_C = 0;
  localparam logic [7:0] CC_ONES = 8'h60;

  // Opcodes.
  localparam logic [7:0] OP_POP_H = 8'h8A;
  localparam logic [7:0] OP_POP_X = 8'h88;
  localparam logic [7:0] OP_ROL_DIR = 8'h39;
  localparam logic [7:0] OP_ROL_A = 8'h49;
  localparam logic [7:0] OP_ROL_X = 8'h59;
  localparam logic [7:0] OP_ROL_IX1 = 8'h69;
  localparam logic [7:0] OP_ROL_IX = 8'h79;
  localparam logic [7:0] OP_ROR_DIR = 8'h36;
  localparam logic [7:0] OP_ROR_A = 8'h46;
  localparam logic [7:0] OP_ROR_X = 8'h56;
  localparam logic [7:0] OP_ROR_IX1 = 8'h66;
  localparam logic [7:0] OP_ROR_IX = 8'h76;
  localparam logic [7:0] OP_RSP = 8'h9C;
  localparam logic [7:0] OP_RTI = 8'h80;
  localparam logic [7:0] OP_RTS = 8'h81;

  // Cycle counts.
  localparam logic [2:0] CYC_POP = 3'h2;
  localparam logic [2:0] CYC_ROT_INH = 3'h1;
  localparam logic [2:0] CYC_ROT_DIR = 3'h4;
  localparam logic [2:0] CYC_ROT_IX1 = 3'h4;
  localparam logic [2:0] CYC_ROT_IX = 3'h3;
  localparam logic [2:0] CYC_ROT_SP1 = 3'h5;
  localparam logic [2:0] CYC_RSP = 3'h1;
  localparam logic [2:0] CYC_RTI = 3'h7;
  localparam logic [2:0] CYC_RTS = 3'h4;

  // Reset values.
  localparam logic [7:0] SP_LOW_RESET = 8'hFF;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] CCR_RST = 8'h68;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    K_BAD = 3'b000, K_POPH = 3'b001, K_POPX = 3'b010, K_ROL = 3'b011,
    K_ROR = 3'b100, K_RSP = 3'b101, K_RTI = 3'b110, K_RTS = 3'b111
  } sprre_kind_e;

  typedef enum logic [2:0] {
    M_NONE = 3'b000, M_A = 3'b001, M_X = 3'b010, M_DIR = 3'b011,
    M_IX1 = 3'b100, M_IX = 3'b101, M_SP1 = 3'b110
  } sprre_mode_e;

  typedef enum logic [2:0] {
    D_NONE = 3'b000, D_H = 3'b001, D_X = 3'b010, D_A = 3'b011,
    D_CCR = 3'b100, D_PCH = 3'b101, D_PCL = 3'b110
  } sprre_dst_e;

  typedef struct packed {
    sprre_kind_e kind;
    sprre_mode_e mode;
    logic [2:0] cycles;
    logic [2:0] npop;
  } sprre_dec_s;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } sprre_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sprre_axi_rsp_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } sprre_mem_req_s;

endpackage

/* File: src/sprre_exec.sv */
// Execution unit for stack pops, rotates through carry, stack pointer reset and returns.
// Assumes an AXI4-Lite master on one clock and a memory that returns read data
// combinationally in the same cycle as a registered read request.
//
// Contract
// RULE1 - Pop of index high, 8A, 2 cycles: increment pointer, load high byte, flags kept.
// RULE2 - Pop of index low, 88, 2 cycles: increment pointer, load low byte, flags kept.
// RULE3 - Rotate left shifts operand up; bit 0 gets carry, carry gets old bit 7.
// RULE4 - Rotate left flags: C old b7, N r7, Z zero, V r7 xor b7.
// RULE5 - Rotate left codes 39,49,59,69,79,9E69 with cycles 4,1,1,4,3,5.
// RULE6 - Rotate right shifts operand down; bit 7 gets carry, carry gets old bit 0.
// RULE7 - Rotate right flags: C old b0, N r7, Z zero, V r7 xor b0.
// RULE8 - Rotate right codes 36,46,56,66,76,9E66 with cycles 4,1,1,4,3,5.
// RULE9 - Both rotates take carry in and give shifted bit out, for chaining.
// RULE10 - Stack pointer reset, 9C, 1 cycle: low pointer byte becomes FF, flags kept.
// RULE11 - Software should set the stack to the top of RAM after reset.
// RULE12 - Interrupt return, 80, 7 cycles: pop flags, A, X, PC high, PC low.
// RULE13 - Interrupt return loads every flag, the mask too, from the popped byte.
// RULE14 - Subroutine return, 81, 4 cycles: pop PC high then PC low, flags kept.
// RULE15 - After subroutine return, fetching resumes at the rebuilt 16-bit address.
// RULE16 - Every pop increments the stack pointer before its read.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module sprre_exec (
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Register bus.
  input wire sprre_pkg::sprre_axi_req_s axi_req,
  output sprre_pkg::sprre_axi_rsp_s axi_rsp,
  // Memory bus.
  output sprre_pkg::sprre_mem_req_s mem_req,
  input wire logic [7:0] mem_rdata,
  // Execution status.
  output logic [15:0] fetch_addr,
  output logic exec_done
);
  import sprre_pkg::*;

  // Whole architectural and bus state in one record. The engine and the register
  // bus share it, so every field has exactly one next-value path through the
  // combinational block below. A write from software and an instruction step can
  // never both update a field, because bus writes are dropped while busy is high.
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx_l;
    logic [7:0] idx_h;
    logic [7:0] condition_code_byte;
    logic [15:0] sp;
    logic [15:0] pc;
    logic busy;
    logic bad;
    logic [2:0] step;
    sprre_dec_s dec;
    logic [15:0] ea;
    sprre_mem_req_s mem;
    logic done;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    sprre_axi_rsp_s rsp;
  } sprre_state_s;

  // The registered copy drives every output directly, which keeps the outputs
  // glitch free. The cost is one cycle of latency on every answer, and both the
  // bus timing and the memory request timing already allow for that cycle.
  sprre_state_s q, d;

  // Opcode decode; the prebyte selects the stack-relative page.
  function automatic sprre_dec_s decode(input logic pre, input logic [7:0] op);
    sprre_dec_s r;
    r = '{kind: K_BAD, mode: M_NONE, cycles: 3'h1, npop: 3'h0};
    if (pre) begin
      case (op)
        OP_ROL_IX1: r = '{kind: K_ROL, mode: M_SP1, cycles: CYC_ROT_SP1, npop: 3'h0}; // RULE5
        OP_ROR_IX1: r = '{kind: K_ROR, mode: M_SP1, cycles: CYC_ROT_SP1, npop: 3'h0}; // RULE8
        default: r.kind = K_BAD;
      endcase
    end else begin
      case (op)
        OP_POP_H: r = '{kind: K_POPH, mode: M_NONE, cycles: CYC_POP, npop: 3'h1}; // RULE1
        OP_POP_X: r = '{kind: K_POPX, mode: M_NONE, cycles: CYC_POP, npop: 3'h1}; // RULE2
        OP_ROL_DIR: r = '{kind: K_ROL, mode: M_DIR, cycles: CYC_ROT_DIR, npop: 3'h0}; // RULE5
        OP_ROL_A: r = '{kind: K_ROL, mode: M_A, cycles: CYC_ROT_INH, npop: 3'h0}; // RULE5
        OP_ROL_X: r = '{kind: K_ROL, mode: M_X, cycles: CYC_ROT_INH, npop: 3'h0}; // RULE5
        OP_ROL_IX1: r = '{kind: K_ROL, mode: M_IX1, cycles: CYC_ROT_IX1, npop: 3'h0}; // RULE5
        OP_ROL_IX: r = '{kind: K_ROL, mode: M_IX, cycles: CYC_ROT_IX, npop: 3'h0}; // RULE5
        OP_ROR_DIR: r = '{kind: K_ROR, mode: M_DIR, cycles: CYC_ROT_DIR, npop: 3'h0}; // RULE8
        OP_ROR_A: r = '{kind: K_ROR, mode: M_A, cycles: CYC_ROT_INH, npop: 3'h0}; // RULE8
        OP_ROR_X: r = '{kind: K_ROR, mode: M_X, cycles: CYC_ROT_INH, npop: 3'h0}; // RULE8
        OP_ROR_IX1: r = '{kind: K_ROR, mode: M_IX1, cycles: CYC_ROT_IX1, npop: 3'h0}; // RULE8
        OP_ROR_IX: r = '{kind: K_ROR, mode: M_IX, cycles: CYC_ROT_IX, npop: 3'h0}; // RULE8
        OP_RSP: r = '{kind: K_RSP, mode: M_NONE, cycles: CYC_RSP, npop: 3'h0}; // RULE10
        OP_RTI: r = '{kind: K_RTI, mode: M_NONE, cycles: CYC_RTI, npop: 3'h5}; // RULE12
        OP_RTS: r = '{kind: K_RTS, mode: M_NONE, cycles: CYC_RTS, npop: 3'h2}; // RULE14
        default: r.kind = K_BAD;
      endcase
    end
    return r;
  endfunction

  // Destination of the n-th pop of a sequence.
  function automatic sprre_dst_e pop_dst(input sprre_kind_e kind, input logic [2:0] n);
    sprre_dst_e r;
    r = D_NONE;
    case (kind)
      K_POPH: r = D_H;
      K_POPX: r = D_X;
      K_RTS: r = (n == 3'h0) ? D_PCH : D_PCL; // RULE14
      K_RTI: begin
        case (n) // RULE12
          3'h0: r = D_CCR;
          3'h1: r = D_A;
          3'h2: r = D_X;
          3'h3: r = D_PCH;
          default: r = D_PCL;
        endcase
      end
      default: r = D_NONE;
    endcase
    return r;
  endfunction

  // The carry takes part in both directions so that software can chain several
  // rotates over a value wider than one byte without losing the bit in between.
  // Rotate through carry; returns carry out above the 8-bit result.
  function automatic logic [8:0] rotate(input logic [7:0] v, input logic c, input logic left);
    return left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]}; // RULE3 RULE6 RULE9
  endfunction

  // Flags after a rotate; V is the new N xor the new C, which equals r7 xor the lost bit.
  function automatic logic [7:0] rot_flags(input logic [7:0] cc, input logic [8:0] r);
    logic [7:0] f;
    f = cc;
    f[CC_C] = r[8]; // RULE4 RULE7
    f[CC_N] = r[7]; // RULE4 RULE7
    f[CC_Z] = (r[7:0] == 8'h00); // RULE4 RULE7
    f[CC_V] = r[7] ^ r[8]; // RULE4 RULE7
    return f;
  endfunction

  // Lanes with a clear strobe keep the old byte, so software can update one register.
  // Byte-lane merge for AXI write strobes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Next-state logic: execution engine first, then the register bus, which only
  // touches architectural state while the engine is idle so the two never collide.
  always_comb begin
    sprre_dec_s dn;
    logic [8:0] rr;
    logic left;
    logic [31:0] wv;
    dn = '{kind: K_BAD, mode: M_NONE, cycles: 3'h1, npop: 3'h0};
    rr = 9'h000;
    left = 1'b0;
    wv = 32'h0000_0000;
    d = q;
    d.mem.rd = 1'b0;
    d.mem.wr = 1'b0;
    d.done = 1'b0;

    // Execution engine; busy lasts exactly the instruction's cycle count.
    // The step counter runs from zero to the count less one. Work that an
    // instruction finishes early simply idles in the remaining steps, so the
    // cycle count seen from outside always matches the documented figure.
    if (q.busy) begin
      left = (q.dec.kind == K_ROL);
      // Pop requests go out one per step. The pointer is raised before the read,
      // so the request of this step already carries the incremented address and
      // the last pushed byte is the first one read back.
      if (q.step < q.dec.npop) begin
        d.sp = q.sp + 16'h0001; // RULE16 RULE1 RULE2
        d.mem.addr = q.sp + 16'h0001; // RULE16
        d.mem.rd = 1'b1;
      end
      // Read data belongs to the request registered one step earlier, so the
      // destination is chosen by the previous pop index. The memory must answer
      // within the cycle in which the read request stands.
      if (q.step != 3'h0 && q.step <= q.dec.npop) begin
        case (pop_dst(q.dec.kind, q.step - 3'h1))
          D_H: d.idx_h = mem_rdata; // RULE1
          D_X: d.idx_l = mem_rdata; // RULE2 RULE12
          D_A: d.acc = mem_rdata; // RULE12
          D_CCR: d.condition_code_byte = mem_rdata | CC_ONES; // RULE13
          D_PCH: d.pc[15:8] = mem_rdata; // RULE12 RULE14 RULE15
          D_PCL: d.pc[7:0] = mem_rdata; // RULE12 RULE14 RULE15
          default: d.pc = q.pc;
        endcase
      end
      // Register rotates finish in their single step. Memory rotates read the
      // operand, rotate it and write it back to the same effective address, which
      // was fixed when the command was accepted and is not recomputed here.
      if (q.dec.kind == K_ROL || q.dec.kind == K_ROR) begin
        if (q.dec.mode == M_A || q.dec.mode == M_X) begin
          if (q.step == 3'h0) begin
            rr = rotate((q.dec.mode == M_A) ? q.acc : q.idx_l, q.condition_code_byte[CC_C], left);
            if (q.dec.mode == M_A) begin
              d.acc = rr[7:0]; // RULE3 RULE6
            end else begin
              d.idx_l = rr[7:0]; // RULE3 RULE6
            end
            d.condition_code_byte = rot_flags(q.condition_code_byte, rr);
          end
        end else if (q.step == 3'h0) begin
          d.mem.addr = q.ea;
          d.mem.rd = 1'b1;
        end else if (q.step == 3'h1) begin
          // Read-modify-write: the operand returned this cycle is written back next.
          rr = rotate(mem_rdata, q.condition_code_byte[CC_C], left); // RULE3 RULE6
          d.mem.addr = q.ea;
          d.mem.wr = 1'b1;
          d.mem.wdata = rr[7:0];
          d.condition_code_byte = rot_flags(q.condition_code_byte, rr);
        end
      end
      // Only the low pointer byte is reset; the high byte keeps its value, so a
      // stack placed above the first page stays on its own page.
      if (q.dec.kind == K_RSP && q.step == 3'h0) begin
        d.sp[7:0] = SP_LOW_RESET; // RULE10
      end
      // The last step clears busy and raises the done pulse for exactly one cycle,
      // which lets a new command be accepted right behind it.
      if (q.step == q.dec.cycles - 3'h1) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.step = 3'h0;
      end else begin
        d.step = q.step + 3'h1;
      end
    end

    // Write address and data are taken in either order and held until both are in.
    if (q.rsp.awready && axi_req.awvalid) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (q.rsp.wready && axi_req.wvalid) begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    // The response stays up until the master takes it; no new address or data is
    // accepted in the meantime, so only one write is ever outstanding.
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = RESP_OKAY;
      case (q.awaddr)
        OFF_CMD: begin
          // A command while busy is dropped; software polls busy first.
          if (!q.busy) begin
            dn = decode(q.wdata[CMD_PRE_BIT], q.wdata[CMD_OP_LSB +: 8]);
            d.bad = (dn.kind == K_BAD);
            d.busy = (dn.kind != K_BAD);
            d.dec = dn;
            d.step = 3'h0;
            case (dn.mode)
              M_DIR: d.ea = {8'h00, q.wdata[CMD_OPND_LSB +: 8]};
              M_IX1: d.ea = {q.idx_h, q.idx_l} + {8'h00, q.wdata[CMD_OPND_LSB +: 8]};
              M_IX: d.ea = {q.idx_h, q.idx_l};
              M_SP1: d.ea = q.sp + {8'h00, q.wdata[CMD_OPND_LSB +: 8]};
              default: d.ea = q.ea;
            endcase
          end
        end
        OFF_STAT: d.rsp.bresp = RESP_OKAY;
        OFF_ACCS: begin
          if (!q.busy) begin
            // The two fixed flag bits are forced high whatever software writes,
            // so a read back never shows a value that the unit cannot hold.
            wv = merge({q.condition_code_byte, q.idx_h, q.idx_l, q.acc}, q.wdata, q.wstrb);
            {d.condition_code_byte, d.idx_h, d.idx_l, d.acc} = wv;
            d.condition_code_byte = wv[31:24] | CC_ONES;
          end
        end
        OFF_PTRS: begin
          if (!q.busy) begin
            {d.pc, d.sp} = merge({q.pc, q.sp}, q.wdata, q.wstrb);
          end
        end
        default: d.rsp.bresp = RESP_SLVERR;
      endcase
    end
    d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
    d.rsp.wready = !d.w_got && !d.rsp.bvalid;

    // Read channel: one read in flight, data captured at the address handshake.
    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (q.rsp.arready && axi_req.arvalid) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = RESP_OKAY;
      d.rsp.rdata = 32'h0000_0000;
      case (axi_req.araddr)
        OFF_CMD: d.rsp.rdata = 32'h0000_0000;
        OFF_STAT: begin
          d.rsp.rdata[STAT_BUSY_BIT] = q.busy;
          d.rsp.rdata[STAT_BAD_BIT] = q.bad;
          d.rsp.rdata[STAT_STEP_LSB +: 3] = q.step;
        end
        OFF_ACCS: d.rsp.rdata = {q.condition_code_byte, q.idx_h, q.idx_l, q.acc};
        OFF_PTRS: d.rsp.rdata = {q.pc, q.sp};
        default: d.rsp.rresp = RESP_SLVERR;
      endcase
    end
    // Address ready is held low while data waits, which limits the read side to
    // one transfer in flight and keeps the captured data stable until taken.
    d.rsp.arready = !d.rsp.rvalid;
  end

  // State register; ready outputs come up one cycle after reset release.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.sp <= SP_RST;
      q.pc <= PC_RST;
      q.condition_code_byte <= CCR_RST;
      q.dec <= '{kind: K_BAD, mode: M_NONE, cycles: 3'h1, npop: 3'h0};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign axi_rsp = q.rsp;
  assign mem_req = q.mem;
  assign fetch_addr = q.pc; // RULE15
  assign exec_done = q.done;

endmodule

/* File: testbench/sprre_mem_model.sv */
// Behavioural memory holding program bytes, operands and the stack.
// Assumes the unit's registered read and write pulses on one clock.
`timescale 1ns/10ps
module sprre_mem_model (
  // Clock.
  input wire logic clock,
  // Memory bus.
  input wire sprre_pkg::sprre_mem_req_s mem_req,
  output logic [7:0] mem_rdata
);
  import sprre_pkg::*;
  logic [7:0] ram [0:65535];
  logic [7:0] last_q = 8'h00;
  // Read data is valid only while rd is high; otherwise the inverse of the last byte,
  // so a late capture cannot pass by luck.
  assign mem_rdata = mem_req.rd ? ram[mem_req.addr] : ~last_q;
  // Writes land on the clock edge that ends the write cycle.
  always @(posedge clock) begin
    if (mem_req.wr) begin
      ram[mem_req.addr] <= mem_req.wdata;
    end
    if (mem_req.rd) begin
      last_q <= mem_rdata;
    end
  end
endmodule

/* File: testbench/sprre_exec_chk.sv */
// Assertion checker for the execution unit, attached to its ports.
// Assumes one clock domain and the registered bus timing of the unit.
`timescale 1ns/10ps
module sprre_exec_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Observed ports.
  input wire sprre_pkg::sprre_axi_req_s axi_req,
  input wire sprre_pkg::sprre_axi_rsp_s axi_rsp,
  input wire sprre_pkg::sprre_mem_req_s mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] fetch_addr,
  input wire logic exec_done
);
  import sprre_pkg::*;
  logic [7:0] rdata_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Last byte seen on the read data, so a write-back can be tied to its source.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_rdata;
    end
  end
  a_pop_preinc: assert property (
    mem_req.rd && $past(mem_req.rd) |-> mem_req.addr == $past(mem_req.addr) + 16'h0001)
    else $error("pop address did not step up by one");
  a_wr_after_rd: assert property (
    mem_req.wr |-> $past(mem_req.rd) && mem_req.addr == $past(mem_req.addr))
    else $error("write-back not at the address just read");
  a_rot_wdata: assert property (
    mem_req.wr |-> mem_req.wdata[7:1] == rdata_q[6:0] || mem_req.wdata[6:0] == rdata_q[7:1])
    else $error("write-back is not a one-place rotate of the read byte");
  a_return_addr: assert property (
    exec_done && $past(mem_req.rd, 2) && $past(mem_req.rd, 3)
    |-> fetch_addr == {$past(mem_rdata, 3), $past(mem_rdata, 2)})
    else $error("fetch address not rebuilt from the two last popped bytes");
  a_b_answer: assert property (
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write response not two cycles after the take");
  a_r_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data not one cycle after the take");
  a_r_hold: assert property (
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped before rready");
  a_done_pulse: assert property (exec_done |=> !exec_done)
    else $error("done longer than one cycle");
endmodule

bind sprre_exec sprre_exec_chk u_chk (
  .clock(clock), .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .mem_req(mem_req), .mem_rdata(mem_rdata), .fetch_addr(fetch_addr),
  .exec_done(exec_done)
);

/* File: testbench/tb.sv */
// Self-checking bench: AXI4-Lite register accesses drive commands to the unit.
// Assumes the memory model as the far side and hierarchical preload of its array.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tb;
  import sprre_pkg::*;
  logic clock;
  logic arst_n;
  sprre_axi_req_s axi_req;
  sprre_axi_rsp_s axi_rsp;
  sprre_mem_req_s mem_req;
  logic [7:0] mem_rdata;
  logic [15:0] fetch_addr;
  logic exec_done;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] d;

  sprre_exec dut (.clock(clock), .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .fetch_addr(fetch_addr),
    .exec_done(exec_done));
  sprre_mem_model mem (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // Free-running clock at 250 MHz.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang anywhere counts as a mismatch and closes the run.
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // One write: address and data offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
    @(posedge clock);
    axi_req.awaddr <= a;
    axi_req.wdata <= wd;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge clock);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
    `CHK("bresp", er, axi_rsp.bresp)
  endtask

  // One read; the data is taken at the edge where rvalid is seen.
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] rd);
    @(posedge clock);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge clock);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
    rd = axi_rsp.rdata;
    `CHK("rresp", er, axi_rsp.rresp)
  endtask

  // Issue a command and count cycles from its response to the done pulse.
  task automatic run(input logic [31:0] cmd, input logic [4:0] en);
    logic [4:0] n;
    axi_wr(OFF_CMD, cmd, RESP_OKAY);
    n = 5'd0;
    do begin
      @(posedge clock);
      n++;
    end while (exec_done !== 1'b1 && n < 5'd20);
    `CHK("cycles", en, n)
  endtask

  logic [7:0] op_t [12] = '{8'h49, 8'h59, 8'h39, 8'h69, 8'h79, 8'h69,
                            8'h46, 8'h56, 8'h36, 8'h66, 8'h76, 8'h66};
  logic [4:0] n_t [6] = '{5'd1, 5'd1, 5'd4, 5'd4, 5'd3, 5'd5};
  logic [7:0] f_t [6] = '{8'h00, 8'h00, 8'h40, 8'h10, 8'h00, 8'h05};

  // Main sequence.
  initial begin
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] cc;
    logic [7:0] got;
    logic [15:0] ea;
    logic c;
    int m;
    axi_req = '0;
    arst_n = 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    axi_rd(OFF_ACCS, RESP_OKAY, d);
    `CHK("reset accs", 32'h6800_0000, d)
    axi_rd(OFF_PTRS, RESP_OKAY, d);
    `CHK("reset ptrs", 32'h0000_00FF, d)
    axi_rd(8'h10, RESP_SLVERR, d);
    `CHK("unmapped data", 32'h0000_0000, d)
    axi_wr(8'h12, 32'h1234_5678, RESP_SLVERR);
    $display("test reset done");
    // Software moves the stack off the direct page before use.
    axi_wr(OFF_PTRS, 32'h0000_01F0, RESP_OKAY);
    mem.ram[16'h01F1] = 8'hA5;
    mem.ram[16'h01F2] = 8'h3C;
    run(32'h0000_008A, 5'd2);
    run(32'h0000_0088, 5'd2);
    axi_rd(OFF_ACCS, RESP_OKAY, d);
    `CHK("pop regs", 32'h68A5_3C00, d)
    axi_rd(OFF_PTRS, RESP_OKAY, d);
    `CHK("pop pointer", 32'h0000_01F2, d)
    $display("test pops done");
    // Every rotate form, with carry in varied so the carry-in path used for chaining is exercised.
    for (int i = 0; i < 12; i++) begin
      m = i % 6;
      v = 8'(i * 8'h53);
      c = i[0];
      cc = 8'h60 | ((i % 3 == 0) ? 8'h18 : 8'h00) | {7'h00, c};
      axi_wr(OFF_ACCS, {cc, 8'h02, v, v}, RESP_OKAY);
      ea = (m == 2) ? 16'h0040 : (m == 5) ? 16'h01F7 : {8'h02, v} + {8'h00, f_t[m]};
      mem.ram[ea] = v;
      run({15'h0000, m == 5, f_t[m], op_t[i]}, n_t[m]);
      r = (i < 6) ? {v[6:0], c} : {c, v[7:1]};
      c = (i < 6) ? v[7] : v[0];
      axi_rd(OFF_ACCS, RESP_OKAY, d);
      got = (m == 0) ? d[7:0] : (m == 1) ? d[15:8] : mem.ram[ea];
      `CHK("rotate result", r, got)
      `CHK("rotate flags", (cc & 8'h78) | {r[7] ^ c, 4'h0, r[7], r == 8'h00, c}, d[31:24])
    end
    $display("test rotates done");
    axi_wr(OFF_ACCS, 32'h6F11_2233, RESP_OKAY);
    run(32'h0000_009C, 5'd1);
    axi_rd(OFF_PTRS, RESP_OKAY, d);
    `CHK("pointer reset", 32'h0000_01FF, d)
    axi_wr(OFF_PTRS, 32'h0000_01E0, RESP_OKAY);
    mem.ram[16'h01E1] = 8'h12;
    mem.ram[16'h01E2] = 8'h34;
    run(32'h0000_0081, 5'd4);
    `CHK("fetch after return", 16'h1234, fetch_addr)
    axi_rd(OFF_PTRS, RESP_OKAY, d);
    `CHK("return ptrs", 32'h1234_01E2, d)
    axi_rd(OFF_ACCS, RESP_OKAY, d);
    `CHK("flags kept", 32'h6F11_2233, d)
    $display("test subroutine return done");
    // Stacked flags have the mask clear, so the return must clear it.
    axi_wr(OFF_PTRS, 32'h0000_01D0, RESP_OKAY);
    mem.ram[16'h01D1] = 8'h81;
    mem.ram[16'h01D2] = 8'h5A;
    mem.ram[16'h01D3] = 8'hC3;
    mem.ram[16'h01D4] = 8'h9A;
    mem.ram[16'h01D5] = 8'hBC;
    run(32'h0000_0080, 5'd7);
    axi_rd(OFF_ACCS, RESP_OKAY, d);
    `CHK("restored regs", 32'hE111_C35A, d)
    axi_rd(OFF_PTRS, RESP_OKAY, d);
    `CHK("restored ptrs", 32'h9ABC_01D5, d)
    `CHK("fetch after irq return", 16'h9ABC, fetch_addr)
    axi_wr(OFF_CMD, 32'h0000_0042, RESP_OKAY);
    axi_rd(OFF_STAT, RESP_OKAY, d);
    `CHK("bad opcode", 2'b10, d[1:0])
    $display("test interrupt return done");
    end_of_test();
  end
endmodule
